// >>> rtl/imcc_pkg.sv
// Package for the I2C master main control block
`default_nettype none
package imcc_pkg;
  // Register map
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [31:0] MAIN_CTRL_RESET = 32'h00000000;
  // Field positions of the main control register
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_ENABLE = 1;
  localparam int POS_MODE = 2;
  localparam int BIT_STANDBY = 7;
  localparam int BIT_FOUR_WIRE = 16;
  localparam int POS_SDA_HOLD = 20;
  localparam int BIT_MEXT_EN = 22;
  localparam int BIT_SEXT_EN = 23;
  localparam int POS_SPEED = 24;
  localparam int BIT_STRETCH = 27;
  localparam int POS_INACT = 28;
  localparam int BIT_LOW_TO = 30;
  localparam logic [31:0] CTRL_WMASK = 32'h7BF1009F;
  // Status bit positions
  localparam int ST_BUS_ERR = 0;
  localparam int ST_LOW_TO = 1;
  localparam int ST_BUS_IDLE = 2;
  localparam int ST_CLK_HELD = 3;
  localparam int ST_MEXT_TO = 4;
  localparam int ST_EN_BUSY = 5;
  localparam int ST_SRST_BUSY = 6;
  // Timing at a 25 MHz clock
  localparam int CLK_HZ = 25000000;
  localparam int LOW_TO_MS = 25;
  localparam int SEXT_TO_MS = 25;
  localparam int MEXT_TO_MS = 10;
  localparam int SCL_PERIOD_US = 10;
  localparam int LOW_TO_CYC = LOW_TO_MS * (CLK_HZ / 1000);
  localparam int SEXT_TO_CYC = SEXT_TO_MS * (CLK_HZ / 1000);
  localparam int MEXT_TO_CYC = MEXT_TO_MS * (CLK_HZ / 1000);
  localparam int SCL_PER_CYC = SCL_PERIOD_US * (CLK_HZ / 1000000);
  localparam int HOLD_NS_1 = 75;
  localparam int HOLD_NS_2 = 450;
  localparam int HOLD_NS_3 = 600;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam logic [4:0] HOLD_CYC_1 = 5'((HOLD_NS_1 + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] HOLD_CYC_2 = 5'((HOLD_NS_2 + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] HOLD_CYC_3 = 5'((HOLD_NS_3 + CLK_NS - 1) / CLK_NS);
  localparam int SYNC_CYC = 3;
  // Decoded settings
  typedef struct packed {
    logic low_to_en;
    logic [1:0] inact_sel;
    logic stretch_after_ack_only;
    logic [1:0] speed;
    logic sext_en;
    logic mext_en;
    logic [1:0] hold_sel;
    logic four_wire_select;
    logic keep_running_in_standby;
  } imcc_cfg_s;
endpackage
`default_nettype wire

// >>> rtl/imcc_main_ctrl.sv
// I2C master main control register with time-out supervision
`default_nettype none
module imcc_main_ctrl
  import imcc_pkg::*;
#(
  parameter int LOW_CYC = LOW_TO_CYC,
  parameter int SEXT_CYC = SEXT_TO_CYC,
  parameter int MEXT_CYC = MEXT_TO_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_err,
  // Protection and sleep
  input wire logic access_protection_controller,
  input wire logic standby_req,
  // Bus pins and transfer engine events
  input wire logic scl_in,
  input wire logic bus_start,
  input wire logic bus_ack,
  input wire logic bus_stop,
  input wire logic engine_clock_hold,
  // Outputs to the transfer engine
  output imcc_cfg_s cfg,
  output logic [2:0] op_mode,
  output logic unit_enabled,
  output logic core_clock_on,
  output logic [4:0] hold_cycles,
  output logic [1:0] speed_eff,
  output logic clock_line_held,
  output logic abort_stop,
  output logic bus_flag_set,
  output logic force_idle
);
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic scl_s1_ff, scl_s2_ff;
  logic [$clog2(SYNC_CYC+1)-1:0] sync_cnt_ff;
  logic en_done_ff;
  logic srst_ff;
  logic [31:0] low_cnt_ff, sext_cnt_ff, mext_cnt_ff;
  logic [15:0] idle_cnt_ff;
  logic [15:0] idle_lim;
  logic in_xfer_ff;
  logic low_fire, sext_fire, mext_fire, any_fire;
  logic bus_err_ff, low_to_ff, mext_to_ff, idle_ff;
  logic wr_ok;
  logic [31:0] bmask;

  assign bmask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
  // Write allowed when not protected and no reset running
  assign wr_ok = reg_wr && (reg_addr == ADDR_MAIN_CTRL) && !access_protection_controller && !srst_ff;

  // Next control value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ok) begin
      if (reg_be[0] && reg_wdata[BIT_SOFT_RESET]) begin
        nxt_ctrl = MAIN_CTRL_RESET;
      end else begin
        // Enable and soft reset are never enable-protected
        nxt_ctrl[BIT_ENABLE] = reg_be[0] ? reg_wdata[BIT_ENABLE] : ctrl_ff[BIT_ENABLE];
        if (!ctrl_ff[BIT_ENABLE]) begin
          nxt_ctrl = (ctrl_ff & ~(CTRL_WMASK & bmask)) | (reg_wdata & CTRL_WMASK & bmask);
          nxt_ctrl[BIT_ENABLE] = reg_be[0] ? reg_wdata[BIT_ENABLE] : ctrl_ff[BIT_ENABLE];
        end
        nxt_ctrl[BIT_SOFT_RESET] = 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= MAIN_CTRL_RESET;
    end else if (srst_ff && sync_cnt_ff == '0) begin
      ctrl_ff <= MAIN_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Soft reset and enable synchronisation delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_ff <= 1'b0;
      sync_cnt_ff <= '0;
      en_done_ff <= 1'b0;
    end else if (wr_ok && reg_be[0] && reg_wdata[BIT_SOFT_RESET]) begin
      srst_ff <= 1'b1;
      sync_cnt_ff <= ($clog2(SYNC_CYC+1))'(SYNC_CYC);
    end else if (sync_cnt_ff != '0) begin
      sync_cnt_ff <= sync_cnt_ff - 1'b1;
    end else if (srst_ff) begin
      srst_ff <= 1'b0;
      en_done_ff <= 1'b0;
    end else if (en_done_ff != ctrl_ff[BIT_ENABLE]) begin
      if (wr_ok) begin
        sync_cnt_ff <= ($clog2(SYNC_CYC+1))'(SYNC_CYC);
      end else begin
        en_done_ff <= ctrl_ff[BIT_ENABLE];
      end
    end else if (wr_ok && reg_be[0] && reg_wdata[BIT_ENABLE] != ctrl_ff[BIT_ENABLE]) begin
      sync_cnt_ff <= ($clog2(SYNC_CYC+1))'(SYNC_CYC);
    end
  end

  // SCL synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
    end
  end

  // Transfer window between start and stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_xfer_ff <= 1'b0;
    end else if (bus_stop || any_fire) begin
      in_xfer_ff <= 1'b0;
    end else if (bus_start) begin
      in_xfer_ff <= 1'b1;
    end
  end

  // SCL low counter, restarted when SCL high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_ff <= '0;
    end else if (scl_s2_ff || !ctrl_ff[BIT_LOW_TO] || low_fire) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= low_cnt_ff + 1'b1;
    end
  end
  assign low_fire = ctrl_ff[BIT_LOW_TO] && !scl_s2_ff && (low_cnt_ff == 32'(LOW_CYC - 1));

  // Cumulative slave extend counter, start to stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sext_cnt_ff <= '0;
    end else if (!in_xfer_ff || !ctrl_ff[BIT_SEXT_EN] || bus_start) begin
      sext_cnt_ff <= '0;
    end else if (!scl_s2_ff) begin
      sext_cnt_ff <= sext_cnt_ff + 1'b1;
    end
  end
  assign sext_fire = ctrl_ff[BIT_SEXT_EN] && in_xfer_ff && (sext_cnt_ff == 32'(SEXT_CYC));

  // Cumulative master extend counter, per start/ack/stop segment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mext_cnt_ff <= '0;
    end else if (!in_xfer_ff || !ctrl_ff[BIT_MEXT_EN] || bus_ack || bus_start) begin
      mext_cnt_ff <= '0;
    end else if (!scl_s2_ff) begin
      mext_cnt_ff <= mext_cnt_ff + 1'b1;
    end
  end
  assign mext_fire = ctrl_ff[BIT_MEXT_EN] && in_xfer_ff && (mext_cnt_ff == 32'(MEXT_CYC));

  assign any_fire = low_fire || sext_fire || mext_fire;
  assign abort_stop = any_fire;
  assign bus_flag_set = any_fire;
  assign clock_line_held = engine_clock_hold && !any_fire;

  // Inactive bus limit in core clocks, 5, 10 or 20 SCL periods
  always_comb begin
    case (ctrl_ff[POS_INACT +: 2])
      2'h1: idle_lim = 16'(5 * SCL_PER_CYC);
      2'h2: idle_lim = 16'(10 * SCL_PER_CYC);
      2'h3: idle_lim = 16'(20 * SCL_PER_CYC);
      default: idle_lim = 16'hFFFF;
    endcase
  end

  // Inactive bus counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_ff <= '0;
    end else if (scl_s2_ff || ctrl_ff[POS_INACT +: 2] == 2'h0 || force_idle) begin
      idle_cnt_ff <= '0;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end
  assign force_idle = (ctrl_ff[POS_INACT +: 2] != 2'h0) && !scl_s2_ff && (idle_cnt_ff == idle_lim);

  // Sticky status; set wins over a clear write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_err_ff <= 1'b0;
      low_to_ff <= 1'b0;
      mext_to_ff <= 1'b0;
      idle_ff <= 1'b1;
    end else if (srst_ff) begin
      bus_err_ff <= 1'b0;
      low_to_ff <= 1'b0;
      mext_to_ff <= 1'b0;
      idle_ff <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == ADDR_STATUS && reg_be[0]) begin
        bus_err_ff <= any_fire | (bus_err_ff & ~reg_wdata[ST_BUS_ERR]);
        low_to_ff <= low_fire | (low_to_ff & ~reg_wdata[ST_LOW_TO]);
        mext_to_ff <= sext_fire | mext_fire | (mext_to_ff & ~reg_wdata[ST_MEXT_TO]);
      end else begin
        bus_err_ff <= bus_err_ff | any_fire;
        low_to_ff <= low_to_ff | low_fire;
        mext_to_ff <= mext_to_ff | sext_fire | mext_fire;
      end
      if (force_idle || bus_stop || any_fire) begin
        idle_ff <= 1'b1;
      end else if (bus_start) begin
        idle_ff <= 1'b0;
      end
    end
  end

  // Decoded settings, taken straight from the register
  always_comb begin
    cfg.low_to_en = ctrl_ff[BIT_LOW_TO];
    cfg.inact_sel = ctrl_ff[POS_INACT +: 2];
    cfg.stretch_after_ack_only = ctrl_ff[BIT_STRETCH];
    cfg.speed = ctrl_ff[POS_SPEED +: 2];
    cfg.sext_en = ctrl_ff[BIT_SEXT_EN];
    cfg.mext_en = ctrl_ff[BIT_MEXT_EN];
    cfg.hold_sel = ctrl_ff[POS_SDA_HOLD +: 2];
    cfg.four_wire_select = ctrl_ff[BIT_FOUR_WIRE];
    cfg.keep_running_in_standby = ctrl_ff[BIT_STANDBY];
  end
  assign op_mode = ctrl_ff[POS_MODE +: 3];
  assign unit_enabled = en_done_ff;
  assign speed_eff = (ctrl_ff[POS_SPEED +: 2] == 2'h3) ? 2'h0 : ctrl_ff[POS_SPEED +: 2];
  assign core_clock_on = !standby_req || ctrl_ff[BIT_STANDBY];

  // SDA hold delay in core clocks
  always_comb begin
    case (ctrl_ff[POS_SDA_HOLD +: 2])
      2'h1: hold_cycles = HOLD_CYC_1;
      2'h2: hold_cycles = HOLD_CYC_2;
      2'h3: hold_cycles = HOLD_CYC_3;
      default: hold_cycles = 5'h00;
    endcase
  end

  // Read data and write error, one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_err <= 1'b0;
    end else begin
      reg_err <= reg_wr && srst_ff;
      reg_rdata <= 32'h00000000;
      if (reg_rd && reg_addr == ADDR_MAIN_CTRL) begin
        reg_rdata <= ctrl_ff | {31'h0, srst_ff};
      end else if (reg_rd && reg_addr == ADDR_STATUS) begin
        reg_rdata <= {25'h0, srst_ff, (en_done_ff != ctrl_ff[BIT_ENABLE]) || sync_cnt_ff != '0,
                      mext_to_ff, clock_line_held, idle_ff, low_to_ff, bus_err_ff};
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/imcc_main_ctrl_checker.sv
// Port-level assertions for the main control block
`default_nettype none
module imcc_main_ctrl_checker
  import imcc_pkg::*;
#(
  parameter int LOW_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins and settings
  input wire logic standby_req,
  input wire logic scl_in,
  input wire imcc_cfg_s cfg,
  input wire logic core_clock_on,
  input wire logic [4:0] hold_cycles,
  input wire logic [1:0] speed_eff,
  // Time-out results
  input wire logic clock_line_held,
  input wire logic abort_stop,
  input wire logic bus_flag_set,
  input wire logic force_idle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [12:0] low_run_ff;
  logic [16:0] ctl_v;
  // Raw SCL low run length, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) low_run_ff <= 13'h0000;
    else if (scl_in) low_run_ff <= 13'h0000;
    else if (low_run_ff != 13'h1FFF) low_run_ff <= low_run_ff + 13'h0001;
  end
  // Expected control readback from settings
  assign ctl_v = {1'b0, cfg.low_to_en, cfg.inact_sel, cfg.stretch_after_ack_only, 1'b0, cfg.speed,
    cfg.sext_en, cfg.mext_en, cfg.hold_sel, 3'h0, cfg.four_wire_select, cfg.keep_running_in_standby};
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read slot");
  AST_RD_CTRL: assert property ($past(reg_rd && reg_addr == ADDR_MAIN_CTRL) |->
    {reg_rdata[31:16], reg_rdata[7]} == $past(ctl_v)) else $error("control readback wrong");
  AST_HOLD: assert property (hold_cycles == (cfg.hold_sel == 2'h0 ? 5'h00 : cfg.hold_sel == 2'h1 ? 5'h02 :
    cfg.hold_sel == 2'h2 ? 5'h0C : 5'h0F)) else $error("hold cycles wrong");
  AST_SPEED: assert property (speed_eff == (cfg.speed == 2'h3 ? 2'h0 : cfg.speed))
    else $error("speed decode wrong");
  AST_CORE: assert property (core_clock_on == !(standby_req && !cfg.keep_running_in_standby))
    else $error("core clock gating wrong");
  AST_ABORT: assert property (abort_stop |-> bus_flag_set && !clock_line_held)
    else $error("abort without flag or with hold");
  AST_LOW_MIN: assert property (abort_stop && cfg.low_to_en && !cfg.sext_en && !cfg.mext_en |->
    low_run_ff >= LOW_CYC) else $error("low time-out early");
  AST_IDLE_MIN: assert property (force_idle |-> cfg.inact_sel != 2'h0 && low_run_ff >=
    (cfg.inact_sel == 2'h1 ? 13'd1250 : cfg.inact_sel == 2'h2 ? 13'd2500 : 13'd5000))
    else $error("idle forced early");
  COV_ABORT: cover property (abort_stop);
  COV_IDLE: cover property (force_idle);
  COV_RD: cover property (reg_rd && reg_addr == ADDR_MAIN_CTRL);
endmodule
`default_nettype wire

// >>> testbench/imcc_far_side.sv
// Far-side bus party driving the clock line
`default_nettype none
module imcc_far_side (
  // Commands from the bench
  input wire logic run,
  input wire logic stretch,
  // Clock line, pulled up when idle
  output logic scl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half-period steps of a 320 ns link clock
  initial begin
    scl = 1'b1;
    forever begin
      #160;
      if (stretch) scl = 1'b0;
      else if (run) scl = ~scl;
      else scl = 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/imcc_main_ctrl_bench.sv
// Bench for the main control block
`default_nettype none
module imcc_main_ctrl_bench
  import imcc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOWC = 50;
  localparam int SEXTC = 60;
  localparam int MEXTC = 30;
  logic clk, rst, reg_wr, reg_rd, reg_err, apc, stby, scl_in, run, stretch, en_q, clk_on, held, abort, flag, idle;
  logic bus_start, bus_ack, bus_stop, hold;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [4:0] hold_cyc;
  logic [1:0] spd;
  logic [2:0] opm;
  imcc_cfg_s cfg;
  logic [4:0] hold_tab [4] = '{5'h00, HOLD_CYC_1, HOLD_CYC_2, HOLD_CYC_3};
  logic [1:0] spd_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [31:0] to_bit [3] = '{32'h40000000, 32'h00800000, 32'h00400000};
  logic [31:0] st_exp [3] = '{32'h03, 32'h11, 32'h11};
  int to_cyc [3] = '{LOWC, SEXTC, MEXTC};
  int err_total = 0;
  int total_checks = 0;
  int n;
  imcc_main_ctrl #(.LOW_CYC(LOWC), .SEXT_CYC(SEXTC), .MEXT_CYC(MEXTC)) imcc_main_ctrl_i (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_be(be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .reg_err(reg_err), .access_protection_controller(apc), .standby_req(stby),
    .scl_in(scl_in), .bus_start(bus_start), .bus_ack(bus_ack), .bus_stop(bus_stop), .engine_clock_hold(hold),
    .cfg(cfg), .op_mode(opm), .unit_enabled(en_q), .core_clock_on(clk_on), .hold_cycles(hold_cyc),
    .speed_eff(spd), .clock_line_held(held), .abort_stop(abort), .bus_flag_set(flag), .force_idle(idle));
  imcc_far_side imcc_far_side_i (.run(run), .stretch(stretch), .scl(scl_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  // Bounded wait for a time-out pulse, then its delay
  task automatic wait_ev(input bit which, input int lo);
    n = 0;
    while ((which ? idle : abort) !== 1'b1 && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n >= lo && n <= lo + 12), 32'h1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    err_total++;
    complete_run();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h00000000;
    be = 4'h0;
    {reg_wr, reg_rd, apc, stby, bus_start, bus_ack, bus_stop, hold, run, stretch} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_MAIN_CTRL, '1, MAIN_CTRL_RESET);
    wr(ADDR_MAIN_CTRL, 32'h00000014, 4'h1);
    chk(32'(opm), 32'h5);
    wr(ADDR_MAIN_CTRL, 32'hFFFFFFFE, 4'h8);
    rd(ADDR_MAIN_CTRL, '1, 32'h7B000014);
    wr(ADDR_MAIN_CTRL, 32'hFFFFFFFE, 4'h6);
    rd(ADDR_MAIN_CTRL, '1, 32'h7BF10014);
    chk(32'(cfg.four_wire_select), 32'h1);
    rd(8'h40, '1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MAIN_CTRL, 32'h14 | 32'(i << 20) | 32'(i << 24), 4'hF);
      chk(32'(hold_cyc), 32'(hold_tab[i]));
      chk(32'(spd), 32'(spd_tab[i]));
      rd(ADDR_STATUS, 32'h60, 32'h0);
    end
    @(posedge clk) stby <= 1'b1;
    wr(ADDR_MAIN_CTRL, 32'h94, 4'hF);
    chk(32'(clk_on), 32'h1);
    wr(ADDR_MAIN_CTRL, 32'h14, 4'hF);
    chk(32'(clk_on), 32'h0);
    @(posedge clk) {stby, apc} <= 2'b01;
    wr(ADDR_MAIN_CTRL, 32'h01000014, 4'hF);
    @(posedge clk) apc <= 1'b0;
    rd(ADDR_MAIN_CTRL, '1, 32'h14);
    wr(ADDR_MAIN_CTRL, 32'h16, 4'h1);
    rd(ADDR_STATUS, 32'h20, 32'h20);
    rd(ADDR_MAIN_CTRL, '1, 32'h16);
    wr(ADDR_MAIN_CTRL, 32'h01000016, 4'h8);
    rd(ADDR_MAIN_CTRL, '1, 32'h16);
    chk(32'(en_q), 32'h1);
    @(posedge clk) hold <= 1'b1;
    // Low, slave extend and master extend time-outs
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_MAIN_CTRL, 32'h14, 4'hF);
      wr(ADDR_MAIN_CTRL, 32'h14 | to_bit[k], 4'hF);
      wr(ADDR_MAIN_CTRL, 32'h16 | to_bit[k], 4'hF);
      @(posedge clk) run <= (k == 0);
      repeat (200) @(posedge clk);
      rd(ADDR_STATUS, 32'h13, 32'h0);
      @(posedge clk) {run, bus_start} <= 2'b01;
      @(posedge clk) bus_start <= 1'b0;
      repeat (10) @(posedge clk);
      stretch <= 1'b1;
      // Master extend: an acknowledge mid-stretch restarts the segment count
      if (k == 2) begin
        repeat (20) @(posedge clk);
        bus_ack <= 1'b1;
        @(posedge clk) bus_ack <= 1'b0;
      end
      wait_ev(1'b0, to_cyc[k]);
      chk(32'({flag, held}), 32'h2);
      @(posedge clk) {stretch, bus_stop} <= 2'b01;
      @(posedge clk) bus_stop <= 1'b0;
      rd(ADDR_STATUS, 32'h13, st_exp[k]);
      wr(ADDR_STATUS, 32'h13, 4'h1);
    end
    // Inactive bus codes
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_MAIN_CTRL, 32'h14, 4'hF);
      wr(ADDR_MAIN_CTRL, 32'h16 | 32'(k << 28), 4'hF);
      repeat (10) @(posedge clk);
      stretch <= 1'b1;
      wait_ev(1'b1, (k == 3 ? 20 : 5 * k) * SCL_PER_CYC);
      @(posedge clk) stretch <= 1'b0;
      repeat (10) @(posedge clk);
    end
    rd(ADDR_STATUS, 32'h0C, 32'h0C);
    wr(ADDR_MAIN_CTRL, 32'h95, 4'h1);
    wr(ADDR_MAIN_CTRL, 32'h14, 4'h1);
    chk(32'(reg_err), 32'h1);
    repeat (8) @(posedge clk);
    rd(ADDR_MAIN_CTRL, '1, 32'h0);
    complete_run();
  end
endmodule
bind imcc_main_ctrl imcc_main_ctrl_checker #(.LOW_CYC(LOW_CYC)) imcc_main_ctrl_checker_i (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_req(standby_req), .scl_in(scl_in),
  .cfg(cfg), .core_clock_on(core_clock_on), .hold_cycles(hold_cycles), .speed_eff(speed_eff),
  .clock_line_held(clock_line_held), .abort_stop(abort_stop), .bus_flag_set(bus_flag_set), .force_idle(force_idle));
`default_nettype wire
